/* core/ebrwc_pkg.sv */
// package: constants and carriers for the external bus ready/wait controller
package ebrwc_pkg;

    localparam int          EBRWC_AW           = 20;
    localparam int          EBRWC_DW           = 32;
    localparam int          EBRWC_CW           = 3;
    // ready sample advance in asynchronous mode, in timing clock cycles
    localparam logic [3:0]  EBRWC_ASYNC_ADV    = 4'h2;
    // bus clock output divider: one timing enable per this many mclk cycles
    localparam logic [3:0]  EBRWC_TIM_DIV      = 4'h1;
    localparam logic [EBRWC_AW-1:0] EBRWC_ADDR_RST = 20'h00001;
    localparam logic [3:0]  EBRWC_ONE          = 4'h1;

    typedef enum logic [2:0]
    {
        EBRWC_IDLE,
        EBRWC_ALIGN,
        EBRWC_LEAD,
        EBRWC_ACTIVE,
        EBRWC_TRAIL
    } ebrwc_state_e;

    // programmed zone timing
    typedef struct packed
    {
        logic [EBRWC_CW-1:0] rd_lead;
        logic [EBRWC_CW-1:0] rd_active;
        logic [EBRWC_CW-1:0] rd_trail;
        logic [EBRWC_CW-1:0] wr_lead;
        logic [EBRWC_CW-1:0] wr_active;
        logic [EBRWC_CW-1:0] wr_trail;
        logic                ready_enable;
        logic                ready_mode;
        logic                bus_32bit;
    } ebrwc_timing_s;

    // request from the internal side
    typedef struct packed
    {
        logic                write;
        logic [EBRWC_AW-1:0] addr;
        logic [EBRWC_DW-1:0] wdata;
    } ebrwc_req_s;

    // external pins
    typedef struct packed
    {
        logic [EBRWC_AW-1:0] addr;
        logic                zone_select_n;
        logic                read_strobe_n;
        logic                lower_write_strobe_n;
        logic                upper_write_strobe_n;
        logic                read_not_write;
        logic [EBRWC_DW-1:0] data_o;
        logic                data_oe_n;
    } ebrwc_pins_s;

endpackage

/* core/ebrwc_clkdiv.sv */
// file: divider making the timing enable and the bus clock output phase
`timescale 1ns/100ps
module ebrwc_clkdiv
    import ebrwc_pkg::*;
(
    input  wire logic mclk_in,
    input  wire logic arst_n_in,
    output logic      tim_en_out,
    output logic      rise_next_out,
    output logic      bus_clock_out
);
    typedef struct packed
    {
        logic [3:0] cnt;
        logic       bclk;
    } ebrwc_div_s;

    ebrwc_div_s st_r;
    ebrwc_div_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (st_r.cnt == EBRWC_TIM_DIV - EBRWC_ONE)
        begin
            st_nxt.cnt  = '0;
            st_nxt.bclk = ~st_r.bclk;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + EBRWC_ONE;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tim_en_out    = (st_r.cnt == EBRWC_TIM_DIV - EBRWC_ONE);
    // the next timing step produces a rising bus clock edge
    assign rise_next_out = ~st_r.bclk;
    assign bus_clock_out = st_r.bclk;
endmodule // ebrwc_clkdiv

/* core/ebrwc_ctrl.sv */
// file: external parallel interface access sequencer with ready wait states
`timescale 1ns/100ps
module ebrwc_ctrl
    import ebrwc_pkg::*;
(
    input  wire logic          mclk_in,
    input  wire logic          arst_n_in,
    input  wire ebrwc_timing_s timing_in,
    input  wire logic          req_valid_in,
    input  wire ebrwc_req_s    req_in,
    output logic               req_ready_out,
    output logic               done_out,
    output logic [EBRWC_DW-1:0] rdata_out,
    input  wire logic          external_ready_input_in,
    input  wire logic [EBRWC_DW-1:0] data_in,
    output ebrwc_pins_s        pins_out,
    output logic               bus_clock_output_out
);
    typedef struct packed
    {
        ebrwc_state_e        state;
        logic [4:0]          cnt;
        logic [4:0]          elapsed;
        ebrwc_req_s          req;
        ebrwc_pins_s         pins;
        logic                done;
        logic [EBRWC_DW-1:0] rdata;
        logic                rdy_s1;
        logic                rdy_s2;
    } ebrwc_st_s;

    ebrwc_st_s st_r;
    ebrwc_st_s st_nxt;
    logic      tim_en;
    logic      rise_next;

    ebrwc_clkdiv u_div
    (
        .mclk_in       (mclk_in),
        .arst_n_in     (arst_n_in),
        .tim_en_out    (tim_en),
        .rise_next_out (rise_next),
        .bus_clock_out (bus_clock_output_out)
    );

    logic [4:0] lead_c;
    logic [4:0] act_c;
    logic [4:0] trail_c;
    logic [4:0] sample_at;
    logic       is_wr;
    logic       rdy_seen;

    always_comb
    begin
        is_wr   = st_r.req.write;
        lead_c  = is_wr ? 5'(timing_in.wr_lead)   : 5'(timing_in.rd_lead);
        act_c   = is_wr ? 5'(timing_in.wr_active) : 5'(timing_in.rd_active);
        trail_c = is_wr ? 5'(timing_in.wr_trail)  : 5'(timing_in.rd_trail);
        // first sample point counted from lead start
        sample_at = lead_c + act_c;
        if (timing_in.ready_mode && (sample_at > 5'(EBRWC_ASYNC_ADV)))
            sample_at = sample_at - 5'(EBRWC_ASYNC_ADV);
        rdy_seen = st_r.rdy_s2;
    end

    // idle pin image: inactive select, strobes and read-not-write, held address with lsb high, data enable kept
    function automatic ebrwc_pins_s idle_pins(input ebrwc_pins_s p, input logic b32);
        ebrwc_pins_s q;
        q                      = p;
        q.addr[0]              = 1'b1;
        q.zone_select_n        = 1'b1;
        q.read_strobe_n        = 1'b1;
        q.lower_write_strobe_n = 1'b1;
        q.upper_write_strobe_n = b32 ? 1'b1 : 1'b1;
        q.read_not_write       = 1'b1;
        return q;
    endfunction

    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.done   = 1'b0;
        st_nxt.rdy_s1 = external_ready_input_in;
        st_nxt.rdy_s2 = st_r.rdy_s1;
        if (tim_en)
        begin
            unique case (st_r.state)
                EBRWC_IDLE:
                begin
                    st_nxt.pins = idle_pins(st_r.pins, timing_in.bus_32bit);
                    if (req_valid_in)
                    begin
                        st_nxt.req = req_in;
                        if (rise_next)
                            st_nxt.state = EBRWC_LEAD;
                        else
                            st_nxt.state = EBRWC_ALIGN;
                    end
                end
                EBRWC_ALIGN:
                begin
                    st_nxt.pins  = idle_pins(st_r.pins, timing_in.bus_32bit);
                    st_nxt.state = EBRWC_LEAD;
                end
                default:
                begin
                end
            endcase
            if (st_nxt.state == EBRWC_LEAD && st_r.state != EBRWC_LEAD)
            begin
                st_nxt.cnt                   = '0;
                st_nxt.elapsed               = '0;
                st_nxt.pins.addr             = st_nxt.req.addr;
                st_nxt.pins.zone_select_n    = 1'b0;
                st_nxt.pins.read_not_write   = ~st_nxt.req.write;
                st_nxt.pins.data_o           = st_nxt.req.wdata;
                st_nxt.pins.data_oe_n        = ~st_nxt.req.write;
                // 16-bit mode: upper strobe pin shows address lsb
                st_nxt.pins.upper_write_strobe_n = timing_in.bus_32bit ? 1'b1 : st_nxt.req.addr[0];
            end
            else if (st_r.state == EBRWC_LEAD)
            begin
                st_nxt.cnt     = st_r.cnt + 5'h01;
                st_nxt.elapsed = st_r.elapsed + 5'h01;
                if (st_r.cnt + 5'h01 >= lead_c)
                begin
                    st_nxt.state = EBRWC_ACTIVE;
                    st_nxt.cnt   = '0;
                    st_nxt.pins.read_strobe_n        = is_wr;
                    st_nxt.pins.lower_write_strobe_n = ~is_wr;
                    if (timing_in.bus_32bit)
                        st_nxt.pins.upper_write_strobe_n = ~is_wr;
                end
            end
            else if (st_r.state == EBRWC_ACTIVE)
            begin
                st_nxt.elapsed = (st_r.elapsed == 5'h1F) ? st_r.elapsed : st_r.elapsed + 5'h01;
                st_nxt.cnt     = st_r.cnt + 5'h01;
                if (timing_in.ready_enable)
                begin
                    // hold while a sample point is reached and ready low
                    if (st_r.elapsed + 5'h01 >= sample_at && !rdy_seen)
                        st_nxt.cnt = st_r.cnt;
                    else if (st_r.elapsed + 5'h01 >= sample_at && st_r.cnt + 5'h01 >= act_c)
                        st_nxt.state = EBRWC_TRAIL;
                end
                else if (st_r.cnt + 5'h01 >= act_c)
                    st_nxt.state = EBRWC_TRAIL;
                if (st_nxt.state == EBRWC_TRAIL)
                begin
                    st_nxt.cnt = '0;
                    if (!is_wr)
                        st_nxt.rdata = data_in;
                    st_nxt.pins.read_strobe_n        = 1'b1;
                    st_nxt.pins.lower_write_strobe_n = 1'b1;
                    if (timing_in.bus_32bit)
                        st_nxt.pins.upper_write_strobe_n = 1'b1;
                end
            end
            else if (st_r.state == EBRWC_TRAIL)
            begin
                st_nxt.cnt = st_r.cnt + 5'h01;
                if (st_r.cnt >= trail_c)
                begin
                    st_nxt.state                 = EBRWC_IDLE;
                    st_nxt.done                  = 1'b1;
                    st_nxt.pins                  = idle_pins(st_r.pins, timing_in.bus_32bit);
                    // release only with read-not-write back high
                    st_nxt.pins.data_oe_n        = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st_r                           <= '0;
            st_r.state                     <= EBRWC_IDLE;
            st_r.pins.addr                 <= EBRWC_ADDR_RST;
            st_r.pins.zone_select_n        <= 1'b1;
            st_r.pins.read_strobe_n        <= 1'b1;
            st_r.pins.lower_write_strobe_n <= 1'b1;
            st_r.pins.upper_write_strobe_n <= 1'b1;
            st_r.pins.read_not_write       <= 1'b1;
            st_r.pins.data_oe_n            <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign pins_out      = st_r.pins;
    assign done_out      = st_r.done;
    assign rdata_out     = st_r.rdata;
    assign req_ready_out = (st_r.state == EBRWC_IDLE) && tim_en;

    a_oe_release: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        !st_r.pins.data_oe_n |-> !st_r.pins.read_not_write)
        else $error("data driven while read-not-write high");

    a_align_idle: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        st_r.state == EBRWC_ALIGN |-> st_r.pins.zone_select_n && st_r.pins.read_strobe_n
            && st_r.pins.lower_write_strobe_n)
        else $error("control active in alignment");

    a_idle_addr: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (st_r.state == EBRWC_IDLE && $past(st_r.state) == EBRWC_IDLE) |-> st_r.pins.addr[0])
        else $error("address lsb low while idle");

    a_lead_rise: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (st_r.state == EBRWC_LEAD && $past(st_r.state) != EBRWC_LEAD) |-> bus_clock_output_out)
        else $error("lead not on rising bus clock");

    a_wait_low: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (st_r.state == EBRWC_ACTIVE && tim_en && timing_in.ready_enable && !rdy_seen
            && st_r.elapsed + 5'h01 >= sample_at) |=> st_r.state == EBRWC_ACTIVE)
        else $error("active ended with ready low");

    a_upper_16: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (!timing_in.bus_32bit && st_r.state == EBRWC_ACTIVE) |-> st_r.pins.upper_write_strobe_n
            == st_r.req.addr[0])
        else $error("upper strobe not address lsb in 16-bit");

    a_trail_data: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (st_r.state == EBRWC_TRAIL && st_r.req.write) |-> !st_r.pins.data_oe_n)
        else $error("write data released in trail");

    a_no_ready: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (st_r.state == EBRWC_ACTIVE && tim_en && !timing_in.ready_enable
            && st_r.cnt + 5'h01 >= 5'(st_r.req.write ? timing_in.wr_active : timing_in.rd_active))
            |=> st_r.state == EBRWC_TRAIL)
        else $error("ready disabled access not timed by counts");

    a_align_low: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        st_r.state == EBRWC_ALIGN |-> !bus_clock_output_out)
        else $error("alignment cycle not on a low bus clock");

    a_align_next: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (st_r.state == EBRWC_ALIGN && tim_en) |=> st_r.state == EBRWC_LEAD)
        else $error("alignment cycle not followed by lead");

    a_align_lines: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        st_r.state == EBRWC_ALIGN |-> st_r.pins.read_not_write && st_r.pins.upper_write_strobe_n
            && st_r.pins.addr[0])
        else $error("line active or address lsb low in alignment");

    a_addr_hold: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (st_r.state != EBRWC_LEAD && $past(st_r.state) == EBRWC_IDLE)
            |-> st_r.pins.addr[EBRWC_AW-1:1] == $past(st_r.pins.addr[EBRWC_AW-1:1]))
        else $error("address moved while idle or aligning");

    a_strobe_32: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (timing_in.bus_32bit && st_r.state == EBRWC_ACTIVE)
            |-> st_r.pins.upper_write_strobe_n == st_r.pins.lower_write_strobe_n)
        else $error("upper strobe differs from lower strobe in 32-bit");

    a_sync_early: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (st_r.state == EBRWC_ACTIVE && tim_en && timing_in.ready_enable && !timing_in.ready_mode
            && st_r.elapsed + 5'h01 < lead_c + act_c) |=> st_r.cnt == $past(st_r.cnt) + 5'h01)
        else $error("synchronous ready sampled before lead plus active");

    a_async_hold: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (st_r.state == EBRWC_ACTIVE && tim_en && timing_in.ready_enable && timing_in.ready_mode
            && !rdy_seen && st_r.elapsed + 5'h01 == lead_c + act_c - 5'(EBRWC_ASYNC_ADV))
            |=> st_r.cnt == $past(st_r.cnt))
        else $error("asynchronous ready not sampled two cycles early");

    a_ready_end: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (st_r.state == EBRWC_ACTIVE && tim_en && timing_in.ready_enable && rdy_seen
            && st_r.elapsed + 5'h01 >= sample_at && st_r.cnt + 5'h01 >= act_c)
            |=> st_r.state == EBRWC_TRAIL)
        else $error("active kept after high ready sample");

    a_done_end: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        st_r.done |-> $past(st_r.state) == EBRWC_TRAIL && st_r.state == EBRWC_IDLE)
        else $error("done pulse outside access end");

    a_trail_quiet: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        st_r.state == EBRWC_TRAIL |-> st_r.pins.read_strobe_n && st_r.pins.lower_write_strobe_n)
        else $error("strobe active in trail");

    a_trail_hold: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (st_r.state == EBRWC_TRAIL && $past(st_r.state) == EBRWC_TRAIL)
            |-> st_r.pins.data_o == $past(st_r.pins.data_o))
        else $error("write data changed in trail");

    a_bus_release: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        ($past(st_r.state) == EBRWC_TRAIL && st_r.state == EBRWC_IDLE)
            |-> st_r.pins.data_oe_n && st_r.pins.read_not_write)
        else $error("data bus kept after access end");

    a_idle_quiet: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        st_r.state == EBRWC_IDLE |-> st_r.pins.zone_select_n && st_r.pins.data_oe_n)
        else $error("select or data driven while idle");
endmodule // ebrwc_ctrl

/* sim/ebrwc_mem_model.sv */
// external memory model that stretches accesses with a programmable ready delay
`timescale 1ns/100ps
module ebrwc_mem_model
    import ebrwc_pkg::*;
(
    input  wire logic                mclk_in,
    input  wire ebrwc_pins_s         pins_in,
    input  wire logic [7:0]          wait_in,
    output logic                     ready_out,
    output logic [EBRWC_DW-1:0]      data_out
);
    logic [7:0]          sel_cnt_r = 8'h00;
    logic [EBRWC_DW-1:0] junk_r    = 32'h0F0F0F0F;

    // cycles since select went low, restarted by every access
    always_ff @(posedge mclk_in)
    begin
        junk_r <= ~junk_r;
        if (pins_in.zone_select_n)
            sel_cnt_r <= 8'h00;
        else if (sel_cnt_r != 8'hFF)
            sel_cnt_r <= sel_cnt_r + 8'h01;
    end

    // ready rises once the stall runs out and holds until select goes high
    assign ready_out = !pins_in.zone_select_n && (sel_cnt_r >= wait_in);
    // real data only under the read strobe, a toggling pattern otherwise
    assign data_out  = !pins_in.read_strobe_n ? {12'hC3A, pins_in.addr} : junk_r;
endmodule // ebrwc_mem_model

/* sim/testbench.sv */
// self-checking bench for the ready/wait access sequencer
`timescale 1ns/100ps
module testbench
    import ebrwc_pkg::*;
;
    typedef struct {
        logic wr; logic en; logic md; logic b32; logic [2:0] act;
        logic [7:0] wt; logic [19:0] a; logic [31:0] d; logic exact;
    } ebrwc_row_s;

    logic          clk       = 1'b0;
    logic          arst_n    = 1'b0;
    logic          req_valid = 1'b0;
    ebrwc_req_s    req       = '0;
    ebrwc_timing_s tcfg      = '0;
    logic [7:0]    wait_cnt  = 8'h00;
    logic [19:0]   last_addr = EBRWC_ADDR_RST;
    logic          req_ready, done, ext_ready, bclk;
    logic [31:0]   rdata, data_bus;
    ebrwc_pins_s   pins;
    logic          prev_rnw = 1'b1, prev_sel_n = 1'b1, seen_stb = 1'b0, mon_on = 1'b0;
    int            miscompares = 0, n_tests = 0, cyc = 0, slen = 0, len, len2;

    ebrwc_row_s rows [8] = '{
        '{1'b0, 1'b0, 1'b0, 1'b1, 3'h3, 8'h07, 20'h12344, 32'h00000000, 1'b1},
        '{1'b1, 1'b0, 1'b1, 1'b1, 3'h4, 8'h07, 20'h0ABCD, 32'hCAFE0001, 1'b1},
        '{1'b1, 1'b0, 1'b0, 1'b0, 3'h3, 8'h07, 20'h00F01, 32'h0000A5A5, 1'b1},
        '{1'b1, 1'b0, 1'b0, 1'b0, 3'h3, 8'h00, 20'h00F02, 32'h00005A5A, 1'b1},
        '{1'b0, 1'b1, 1'b0, 1'b1, 3'h3, 8'h02, 20'h55554, 32'h00000000, 1'b1},
        '{1'b1, 1'b1, 1'b0, 1'b1, 3'h3, 8'h02, 20'h2AAAA, 32'h87654321, 1'b1},
        '{1'b0, 1'b1, 1'b1, 1'b1, 3'h3, 8'h02, 20'h11110, 32'h00000000, 1'b0},
        '{1'b1, 1'b1, 1'b1, 1'b1, 3'h3, 8'h02, 20'h22220, 32'hFEDCBA98, 1'b0}
    };

    ebrwc_ctrl i_dut (.mclk_in(clk), .arst_n_in(arst_n), .timing_in(tcfg), .req_valid_in(req_valid),
        .req_in(req), .req_ready_out(req_ready), .done_out(done), .rdata_out(rdata),
        .external_ready_input_in(ext_ready), .data_in(data_bus), .pins_out(pins),
        .bus_clock_output_out(bclk));
    ebrwc_mem_model i_mem (.mclk_in(clk), .pins_in(pins), .wait_in(wait_cnt),
        .ready_out(ext_ready), .data_out(data_bus));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic cfg(input logic en, input logic md, input logic b32, input logic [2:0] act);
        tcfg <= '{3'h2, act, 3'h2, 3'h2, act, 3'h2, en, md, b32};
    endtask

    // one access: hold the request until taken, then wait for the end pulse
    task automatic acc(input logic wr, input logic [19:0] a, input logic [31:0] d, output int n_stb);
        int n;
        n = 0;
        req <= '{write: wr, addr: a, wdata: d};
        req_valid <= 1'b1;
        @(posedge clk);
        while (req_ready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge clk);
        end
        req_valid <= 1'b0;
        n = 0;
        @(posedge clk);
        while (done !== 1'b1 && n < 200)
        begin
            n++;
            @(posedge clk);
        end
        chk(32'(n < 200), 32'h1);
        n_stb = slen;
        if (!wr)
            chk(rdata, {12'hC3A, a});
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            test_done();
        end
    end

    // pin monitor: idle levels, alignment, strobe reuse, data hold and release
    always @(posedge clk)
    begin
        if (req_valid && req_ready === 1'b1)
        begin
            slen = 0;
            seen_stb = 1'b0;
        end
        else if (pins.read_strobe_n === 1'b0 || pins.lower_write_strobe_n === 1'b0)
        begin
            slen++;
            seen_stb = 1'b1;
        end
        if (mon_on && arst_n)
        begin
            if (pins.zone_select_n)
            begin
                chk(pins.addr, {last_addr[19:1], 1'b1});
                chk({pins.read_strobe_n, pins.lower_write_strobe_n, pins.read_not_write}, 32'h7);
            end
            else
            begin
                last_addr = req.addr;
                if (prev_sel_n)
                    chk(bclk, 32'h1);
                chk(pins.upper_write_strobe_n, tcfg.bus_32bit ? pins.lower_write_strobe_n : req.addr[0]);
                if (!pins.read_not_write && pins.lower_write_strobe_n && seen_stb)
                begin
                    chk(pins.data_o, req.wdata);
                    chk(pins.data_oe_n, 32'h0);
                end
            end
            if (prev_rnw && pins.read_not_write)
                chk(pins.data_oe_n, 32'h1);
        end
        prev_rnw = pins.read_not_write;
        prev_sel_n = pins.zone_select_n;
    end

    initial
    begin
        repeat (2) @(posedge clk);
        chk({pins.addr, pins.zone_select_n, pins.data_oe_n, bclk}, {EBRWC_ADDR_RST, 3'h6});
        arst_n <= 1'b1;
        @(posedge clk);
        mon_on = 1'b1;
        foreach (rows[i])
        begin
            cfg(rows[i].en, rows[i].md, rows[i].b32, rows[i].act);
            wait_cnt <= rows[i].wt;
            acc(rows[i].wr, rows[i].a, rows[i].d, len);
            if (rows[i].exact)
                chk(32'(len), 32'(rows[i].act));
            else
                // early asynchronous sample still finds ready low twice
                chk(32'(len), 32'(rows[i].act) + 32'h2);
        end
        // stall of 10 against 13 cycles: every wait cycle must stretch the strobe by one
        for (int m = 0; m < 4; m++)
        begin
            cfg(1'b1, m[0], 1'b1, 3'h3);
            wait_cnt <= 8'h0A;
            acc(m[1], 20'h3C3C0, 32'h600DF00D, len);
            wait_cnt <= 8'h0D;
            acc(m[1], 20'h3C3C2, 32'h1234ABCD, len2);
            chk(32'(len2 - len), 32'h3);
            chk(32'(len > 3), 32'h1);
        end
        // reset in the middle of a stalled access
        cfg(1'b1, 1'b0, 1'b1, 3'h3);
        wait_cnt <= 8'h40;
        req <= '{write: 1'b1, addr: 20'h0F0F0, wdata: 32'h0BADBEEF};
        req_valid <= 1'b1;
        repeat (8) @(posedge clk);
        mon_on = 1'b0;
        arst_n <= 1'b0;
        req_valid <= 1'b0;
        repeat (2) @(posedge clk);
        chk({pins.addr, pins.zone_select_n, pins.data_oe_n, bclk}, {EBRWC_ADDR_RST, 3'h6});
        last_addr = EBRWC_ADDR_RST;
        arst_n <= 1'b1;
        wait_cnt <= 8'h00;
        @(posedge clk);
        mon_on = 1'b1;
        acc(1'b0, 20'h00777, 32'h00000000, len);
        chk(32'(len), 32'h3);
        test_done();
    end
endmodule // testbench
